/* design/cfd_pkg.sv */
// Package for the frame fan-out DMA channel: register offsets, field positions, reset values, timing.
// Assumes one 50 MHz clock and a plain register port with 32-bit data.
package cfd_pkg;
    localparam logic [5:0]  OFF_SOURCE_ADDRESS = 6'h00;
    localparam logic [5:0]  OFF_DEST_ADDRESS   = 6'h04;
    localparam logic [5:0]  OFF_TRANSFER_SIZE  = 6'h08;
    localparam logic [5:0]  OFF_TRANSFER_MODE  = 6'h0C;
    localparam logic [5:0]  OFF_CHANNEL_CTRL   = 6'h10;
    localparam logic [5:0]  OFF_SCATTER_INC    = 6'h14;
    localparam logic [5:0]  OFF_SCATTER_CTRL   = 6'h18;
    localparam logic [5:0]  OFF_TRIGGER_SEL    = 6'h1C;
    localparam logic [5:0]  OFF_BUFFER_CTRL    = 6'h20;
    localparam logic [5:0]  OFF_DESC_POINTER   = 6'h24;
    localparam logic [5:0]  OFF_DESC_UPDATE    = 6'h28;
    localparam logic [5:0]  OFF_MASTER_CTRL    = 6'h2C;
    localparam logic [5:0]  OFF_STATUS         = 6'h30;
    localparam logic [5:0]  OFF_DESC_WINDOW    = 6'h34;
    // Channel control fields
    localparam int          BIT_CHANNEL_ENABLE = 0;
    localparam int          BIT_PRELOAD        = 4;
    localparam int          BIT_DESC_MODE      = 5;
    // Transfer mode fields
    localparam int          POS_SRC_SIZE       = 0;
    localparam int          POS_DST_SIZE       = 2;
    localparam int          BIT_SRC_INC        = 4;
    localparam int          BIT_DST_INC        = 5;
    localparam int          BIT_HW_REQUEST     = 6;
    // Trigger select fields
    localparam int          POS_TRIG_SRC       = 0;
    localparam int          BIT_TRANS_LIMIT    = 16;
    localparam int          POS_TRANSFER_COUNT = 8;
    // Descriptor word layout: continuation flag and link
    localparam int          BIT_CONTINUATION   = 0;
    localparam int          POS_LINK           = 2;
    // Descriptor update select bits
    localparam int          BIT_UPD_SRC        = 0;
    localparam int          BIT_UPD_DST        = 1;
    localparam int          BIT_UPD_SIZE       = 2;
    // Values
    localparam logic [1:0]  SIZE_LONGWORD      = 2'h2;
    localparam logic [7:0]  BLOCK_LONGWORDS    = 8'h13;
    localparam logic [31:0] BLOCK_BYTES        = 32'h0000_004C;
    localparam logic [7:0]  TRIG_UNIT0_FIRST   = 8'h2D;
    localparam logic [7:0]  TRIG_UNIT0_LAST    = 8'h30;
    localparam logic [7:0]  TRIG_UNIT1_FIRST   = 8'h35;
    localparam logic [7:0]  TRIG_UNIT1_LAST    = 8'h38;
    localparam logic [4:0]  MASTER_IDENT_RESET = 5'h1C;
    localparam logic [7:0]  BUFFER_LIMIT_RESET = 8'h80;
    localparam logic [31:0] CTRL_RESET         = 32'h0000_0000;
    localparam logic [31:0] MODE_RESET         = 32'h0000_0000;
    // Guard error is seen this many nanoseconds after the blocked access
    localparam int          GUARD_LAG_NS       = 60;
    localparam int          CLK_PERIOD_NS      = 20;
    localparam int          GUARD_LAG_CYCLES   = (GUARD_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  GUARD_LAG          = 4'(GUARD_LAG_CYCLES);
endpackage

/* design/cfd_desc_mem.sv */
// Descriptor memory: four words per descriptor, registered read data.
// Assumes one writer from the register port and one reader from the channel.
`timescale 1ns/10ps
module cfd_desc_mem #(
    parameter int DEPTH  = 32,
    parameter int AW     = 5
) (
    input  wire logic          core_clk_i,
    input  wire logic          we_i,
    input  wire logic [AW-1:0] waddr_i,
    input  wire logic [31:0]   wdata_i,
    input  wire logic [AW-1:0] raddr_i,
    output logic      [31:0]   rdata_o
);
    logic [31:0] mem [DEPTH];

    always_ff @(posedge core_clk_i) begin
        if (we_i) begin
            mem[waddr_i] <= wdata_i;
        end
        rdata_o <= mem[raddr_i];
    end
endmodule

/* design/cfd_channel.sv */
// Frame fan-out DMA channel: descriptor-chained longword copier with guard check.
// Assumes a simple memory master that answers in the cycle after a request and a guard verdict per access.
//
// Functional notes
// - every access is one longword
// - both addresses increment; nineteen-longword blocks
// - window is nineteen longwords at 76 bytes
// - start only on selected hardware request
// - codes 45-48 unit0, 53-56 unit1
// - every access carries master identifier 1C
// - reload addresses and count from next descriptor
// - continuation flag re-arms the channel enable
// - zero size forces descriptor lookup first
// - without preload, fetch descriptor after trigger
// - descriptor mode keeps channel active autonomously
// - transaction size is count times access size
// - count covers five steps of nineteen
// - channel and descriptor interrupts stay off
// - update select rewrites source, destination, size
// - last link returns to first descriptor
// - working addresses increment, byte count decrements
// - first step copies FIFO window to RAM
// - later steps copy RAM to queues zero to three
// - whole window moved so queue advances
// - guard refusal suppresses access, stops with error
// - late error report, first blocked access suppressed
// - request while busy flags request overflow
`timescale 1ns/10ps
module cfd_channel #(
    parameter int DESC_DEPTH = 32,
    parameter int DESC_AW    = 5
) (
    input  wire logic        core_clk_i,
    input  wire logic        srst_i,
    input  wire logic [5:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_write_i,
    input  wire logic        reg_read_i,
    output logic      [31:0] reg_rdata_o,
    input  wire logic [15:0] hw_request_i,
    output logic             bus_req_o,
    output logic             bus_write_o,
    output logic      [31:0] bus_addr_o,
    output logic      [31:0] bus_wdata_o,
    output logic      [1:0]  bus_size_o,
    output logic      [4:0]  bus_ident_o,
    input  wire logic [31:0] bus_rdata_i,
    input  wire logic        guard_allow_i,
    output logic             busy_o,
    output logic             addr_error_o,
    output logic             req_overflow_o
);
    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_FETCH = 3'h1,
        ST_LOAD  = 3'h2,
        ST_READ  = 3'h3,
        ST_WRITE = 3'h4,
        ST_NEXT  = 3'h5,
        ST_STOP  = 3'h6,
        ST_CATCH = 3'h7
    } cfd_state_t;

    typedef struct packed {
        cfd_state_t  state;
        logic [31:0] src;
        logic [31:0] dst;
        logic [31:0] size;
        logic [31:0] mode;
        logic [31:0] ctrl;
        logic [31:0] sg_inc;
        logic [31:0] sg_ctrl;
        logic [31:0] trig;
        logic [31:0] bufcr;
        logic [31:0] dptr;
        logic [31:0] dupd;
        logic [31:0] master;
        logic [31:0] data;
        logic [1:0]  word;
        logic [7:0]  steps;
        logic        pend_err;
        logic [3:0]  lag;
        logic        err;
        logic        ovf;
        logic [31:0] rdata;
        logic [DESC_AW-1:0] dwin;
    } cfd_regs_t;

    cfd_regs_t r;
    cfd_regs_t next_r;

    logic [15:0] req_meta;
    logic [15:0] req_sync;
    logic [15:0] req_prev;
    logic [31:0] desc_rdata;
    logic        desc_we;
    logic [DESC_AW-1:0] desc_raddr;
    logic [7:0]  trig_code;
    logic [3:0]  trig_index;
    logic        trig_valid;
    logic        trigger;

    default clocking cfd_cb @(posedge core_clk_i);
    endclocking
    default disable iff (srst_i);

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            req_meta <= 16'h0000;
            req_sync <= 16'h0000;
            req_prev <= 16'h0000;
        end else begin
            req_meta <= hw_request_i;
            req_sync <= req_meta;
            req_prev <= req_sync;
        end
    end

    // Map trigger code to request line
    always_comb begin
        trig_code  = r.trig[cfd_pkg::POS_TRIG_SRC +: 8];
        trig_index = 4'h0;
        trig_valid = 1'b0;
        if (trig_code >= cfd_pkg::TRIG_UNIT0_FIRST && trig_code <= cfd_pkg::TRIG_UNIT0_LAST) begin
            trig_index = 4'(trig_code - cfd_pkg::TRIG_UNIT0_FIRST);
            trig_valid = 1'b1;
        end else if (trig_code >= cfd_pkg::TRIG_UNIT1_FIRST && trig_code <= cfd_pkg::TRIG_UNIT1_LAST) begin
            trig_index = 4'(4'h4 + 4'(trig_code - cfd_pkg::TRIG_UNIT1_FIRST));
            trig_valid = 1'b1;
        end
    end

    // Rising request edge, only when hardware request mode selected
    assign trigger = trig_valid && r.mode[cfd_pkg::BIT_HW_REQUEST]
                   && req_sync[trig_index] && !req_prev[trig_index];

    assign desc_we    = reg_write_i && reg_addr_i == cfd_pkg::OFF_DESC_WINDOW;
    assign desc_raddr = DESC_AW'(r.dptr[cfd_pkg::POS_LINK +: DESC_AW] + DESC_AW'(r.word));

    cfd_desc_mem #(
        .DEPTH (DESC_DEPTH),
        .AW    (DESC_AW)
    ) u_desc_mem (
        .core_clk_i (core_clk_i),
        .we_i       (desc_we),
        .waddr_i    (r.dwin),
        .wdata_i    (reg_wdata_i),
        .raddr_i    (desc_raddr),
        .rdata_o    (desc_rdata)
    );

    always_comb begin
        next_r = r;
        // Register writes
        if (reg_write_i) begin
            unique case (reg_addr_i)
                cfd_pkg::OFF_SOURCE_ADDRESS: next_r.src     = reg_wdata_i;
                cfd_pkg::OFF_DEST_ADDRESS:   next_r.dst     = reg_wdata_i;
                cfd_pkg::OFF_TRANSFER_SIZE:  next_r.size    = reg_wdata_i;
                cfd_pkg::OFF_TRANSFER_MODE:  next_r.mode    = reg_wdata_i;
                cfd_pkg::OFF_CHANNEL_CTRL:   next_r.ctrl    = reg_wdata_i;
                cfd_pkg::OFF_SCATTER_INC:    next_r.sg_inc  = reg_wdata_i;
                cfd_pkg::OFF_SCATTER_CTRL:   next_r.sg_ctrl = reg_wdata_i;
                cfd_pkg::OFF_TRIGGER_SEL:    next_r.trig    = reg_wdata_i;
                cfd_pkg::OFF_BUFFER_CTRL:    next_r.bufcr   = reg_wdata_i;
                cfd_pkg::OFF_DESC_POINTER: begin
                    // Pointer also places the descriptor write window
                    next_r.dptr = reg_wdata_i;
                    next_r.dwin = reg_wdata_i[cfd_pkg::POS_LINK +: DESC_AW];
                end
                cfd_pkg::OFF_DESC_UPDATE:    next_r.dupd    = reg_wdata_i;
                cfd_pkg::OFF_MASTER_CTRL:    next_r.master  = reg_wdata_i;
                cfd_pkg::OFF_STATUS: begin
                    // Writing one clears; a same-cycle set below wins
                    if (reg_wdata_i[0]) next_r.err = 1'b0;
                    if (reg_wdata_i[1]) next_r.ovf = 1'b0;
                end
                cfd_pkg::OFF_DESC_WINDOW:    next_r.dwin    = DESC_AW'(r.dwin + 1'b1);
                default: ;
            endcase
        end
        // Register reads, answer next cycle
        next_r.rdata = 32'h0000_0000;
        if (reg_read_i) begin
            unique case (reg_addr_i)
                cfd_pkg::OFF_SOURCE_ADDRESS: next_r.rdata = r.src;
                cfd_pkg::OFF_DEST_ADDRESS:   next_r.rdata = r.dst;
                cfd_pkg::OFF_TRANSFER_SIZE:  next_r.rdata = r.size;
                cfd_pkg::OFF_TRANSFER_MODE:  next_r.rdata = r.mode;
                cfd_pkg::OFF_CHANNEL_CTRL:   next_r.rdata = r.ctrl;
                cfd_pkg::OFF_SCATTER_INC:    next_r.rdata = r.sg_inc;
                cfd_pkg::OFF_SCATTER_CTRL:   next_r.rdata = r.sg_ctrl;
                cfd_pkg::OFF_TRIGGER_SEL:    next_r.rdata = r.trig;
                cfd_pkg::OFF_BUFFER_CTRL:    next_r.rdata = r.bufcr;
                cfd_pkg::OFF_DESC_POINTER:   next_r.rdata = r.dptr;
                cfd_pkg::OFF_DESC_UPDATE:    next_r.rdata = r.dupd;
                cfd_pkg::OFF_MASTER_CTRL:    next_r.rdata = r.master;
                cfd_pkg::OFF_STATUS:         next_r.rdata = {24'h000000, 1'b0, r.state, 2'(0),
                                                             r.ovf, r.err};
                default:                     next_r.rdata = 32'h0000_0000;
            endcase
        end
        // Request while busy
        if (trigger && r.state != ST_IDLE && r.state != ST_STOP) begin
            next_r.ovf = 1'b1;
        end
        unique case (r.state)
            ST_IDLE: begin
                next_r.word = 2'h0;
                if (trigger && r.ctrl[cfd_pkg::BIT_CHANNEL_ENABLE]) begin
                    next_r.steps = r.trig[cfd_pkg::POS_TRANSFER_COUNT +: 8];
                    // Zero size or descriptor mode without preload fetches after the trigger
                    if (r.size == 32'h0000_0000 || (r.ctrl[cfd_pkg::BIT_DESC_MODE]
                        && !r.ctrl[cfd_pkg::BIT_PRELOAD])) begin
                        next_r.state = ST_FETCH;
                    end else begin
                        next_r.state = ST_READ;
                    end
                end
            end
            ST_FETCH: begin
                next_r.state = ST_LOAD;
            end
            ST_LOAD: begin
                // Descriptor words: source, destination, size, link; rewrite selected registers
                unique case (r.word)
                    2'h0: if (r.dupd[cfd_pkg::BIT_UPD_SRC])  next_r.src  = desc_rdata;
                    2'h1: if (r.dupd[cfd_pkg::BIT_UPD_DST])  next_r.dst  = desc_rdata;
                    2'h2: if (r.dupd[cfd_pkg::BIT_UPD_SIZE]) next_r.size = desc_rdata;
                    2'h3: begin
                        next_r.dptr = desc_rdata;
                        next_r.ctrl[cfd_pkg::BIT_CHANNEL_ENABLE] = desc_rdata[cfd_pkg::BIT_CONTINUATION];
                    end
                    default: ;
                endcase
                next_r.word = 2'(r.word + 1'b1);
                next_r.state = (r.word == 2'h3) ? ST_READ : ST_FETCH;
            end
            ST_READ: begin
                next_r.word = 2'h0;
                if (r.size == 32'h0000_0000) begin
                    next_r.state = ST_NEXT;
                end else if (!guard_allow_i) begin
                    next_r.pend_err = 1'b1;
                    next_r.lag = cfd_pkg::GUARD_LAG;
                    next_r.state = ST_STOP;
                end else begin
                    next_r.state = ST_CATCH;
                end
            end
            ST_CATCH: begin
                // Read data stands in the cycle after the read request
                next_r.data = bus_rdata_i;
                next_r.state = ST_WRITE;
            end
            ST_WRITE: begin
                if (!guard_allow_i) begin
                    next_r.pend_err = 1'b1;
                    next_r.lag = cfd_pkg::GUARD_LAG;
                    next_r.state = ST_STOP;
                end else begin
                    next_r.src = r.mode[cfd_pkg::BIT_SRC_INC] ? r.src + 32'h4 : r.src;
                    next_r.dst = r.mode[cfd_pkg::BIT_DST_INC] ? r.dst + 32'h4 : r.dst;
                    next_r.size = r.size - 32'h4;
                    next_r.state = (r.size == 32'h4) ? ST_NEXT : ST_READ;
                end
            end
            ST_NEXT: begin
                // Block done: count one step, chain on in descriptor mode
                if (r.steps > 8'h0) next_r.steps = 8'(r.steps - cfd_pkg::BLOCK_LONGWORDS);
                if (r.ctrl[cfd_pkg::BIT_DESC_MODE] && r.steps > cfd_pkg::BLOCK_LONGWORDS) begin
                    next_r.state = ST_FETCH;
                end else if (r.ctrl[cfd_pkg::BIT_DESC_MODE]) begin
                    next_r.size = 32'h0000_0000;
                    next_r.state = ST_IDLE;
                end else begin
                    next_r.ctrl[cfd_pkg::BIT_CHANNEL_ENABLE] = 1'b0;
                    next_r.state = ST_IDLE;
                end
            end
            ST_STOP: begin
                // Guard verdict lags; error flag raised after the slower guard reports
                next_r.ctrl[cfd_pkg::BIT_CHANNEL_ENABLE] = 1'b0;
                if (r.pend_err) begin
                    if (r.lag == 4'h0) begin
                        next_r.err = 1'b1;
                        next_r.pend_err = 1'b0;
                    end else begin
                        next_r.lag = 4'(r.lag - 1'b1);
                    end
                end else if (reg_write_i && reg_addr_i == cfd_pkg::OFF_CHANNEL_CTRL
                             && reg_wdata_i[cfd_pkg::BIT_CHANNEL_ENABLE]) begin
                    next_r.ctrl = reg_wdata_i;
                    next_r.state = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (srst_i) begin
            r        <= '0;
            r.state  <= ST_IDLE;
            r.mode   <= cfd_pkg::MODE_RESET;
            r.ctrl   <= cfd_pkg::CTRL_RESET;
            r.bufcr  <= {24'h000000, cfd_pkg::BUFFER_LIMIT_RESET};
            r.master <= {27'h0000000, cfd_pkg::MASTER_IDENT_RESET};
        end else begin
            r <= next_r;
        end
    end

    // Access drives: write strobe suppressed when the guard refuses; request still driven
    always_comb begin
        bus_req_o   = (r.state == ST_READ && r.size != 32'h0000_0000) || r.state == ST_WRITE;
        bus_write_o = (r.state == ST_WRITE) && guard_allow_i;
        bus_addr_o  = (r.state == ST_WRITE) ? r.dst : r.src;
        bus_size_o  = cfd_pkg::SIZE_LONGWORD;
        bus_ident_o = r.master[4:0];
    end
    assign bus_wdata_o    = r.data;
    assign reg_rdata_o    = r.rdata;
    assign busy_o         = r.state != ST_IDLE && r.state != ST_STOP;
    assign addr_error_o   = r.err;
    assign req_overflow_o = r.ovf;

    // Checks on the channel's own sequencing
    a_start_on_trigger: assert property (
        r.state == ST_IDLE && !trigger |=> r.state == ST_IDLE)
        else $error("channel left idle without a trigger");
    a_address_step: assert property (
        r.state == ST_WRITE && guard_allow_i && r.mode[cfd_pkg::BIT_SRC_INC] |=> r.src == $past(r.src) + 32'h4)
        else $error("source address did not step by one longword");
    a_continuation_rearm: assert property (
        r.state == ST_LOAD && r.word == 2'h3
        |=> r.ctrl[cfd_pkg::BIT_CHANNEL_ENABLE] == $past(desc_rdata[cfd_pkg::BIT_CONTINUATION]))
        else $error("continuation flag did not set the channel enable");
    a_guard_stop: assert property (
        bus_req_o && !guard_allow_i |=> r.state == ST_STOP)
        else $error("refused access did not stop the channel");
    a_error_reported: assert property (
        r.state == ST_STOP && r.pend_err |-> ##[1:8] addr_error_o)
        else $error("blocked access raised no address error");
    a_request_overflow: assert property (
        trigger && busy_o |=> req_overflow_o)
        else $error("request while busy raised no overflow");
    c_chain_last_step: cover property (r.state == ST_NEXT && r.steps == cfd_pkg::BLOCK_LONGWORDS);
    c_request_overflow: cover property ($rose(req_overflow_o));
    c_address_error: cover property ($rose(addr_error_o));
endmodule

/* verification/cfd_mem_model.sv */
// Far-side memory model: receive FIFO window, RAM frame buffers, transmit queue windows, access guard.
// Assumes read data is sampled by the channel in the cycle after its request.
`timescale 1ns/10ps
module cfd_mem_model #(
    parameter logic [31:0] FIFO_BASE = 32'h0000_1000
) (
    input  wire logic        core_clk_i,
    input  wire logic        bus_req_i,
    input  wire logic        bus_write_i,
    input  wire logic [31:0] bus_addr_i,
    input  wire logic [31:0] bus_wdata_i,
    output logic      [31:0] bus_rdata_o,
    output logic             guard_allow_o,
    input  wire logic        deny_i
);
    logic [31:0] mem [logic [31:0]];
    int          entry = 0;
    int          n_rd  = 0;
    initial bus_rdata_o = 32'h0000_0000;
    assign guard_allow_o = !deny_i;
    function automatic logic [31:0] frame_word(int e, int i);
        return {e[15:0], i[15:0]} ^ 32'hA5A5_0000;
    endfunction
    always @(posedge core_clk_i) begin
        if (bus_req_i && !bus_write_i && guard_allow_o) begin
            if (bus_addr_i >= FIFO_BASE && bus_addr_i < FIFO_BASE + 32'h0000_004C) begin
                bus_rdata_o <= frame_word(entry, int'((bus_addr_i - FIFO_BASE) >> 2));
                n_rd = n_rd + 1;
                // A fully read window moves the FIFO on to its next entry
                if (n_rd == 19) begin
                    n_rd  = 0;
                    entry = entry + 1;
                end
            end else begin
                bus_rdata_o <= mem.exists(bus_addr_i) ? mem[bus_addr_i] : 32'h0000_0000;
            end
        end else begin
            // Released data lines show no stale value
            bus_rdata_o <= ~bus_rdata_o;
        end
        if (bus_req_i && bus_write_i && guard_allow_o) begin
            mem[bus_addr_i] = bus_wdata_i;
        end
    end
endmodule

/* verification/tb_can_frame_fanout_dma_channel.sv */
// Self-checking bench for the frame fan-out DMA channel.
// Assumes request bit n pairs with the n-th trigger code and descriptors are entered word by word.
`timescale 1ns/10ps
module tb_can_frame_fanout_dma_channel;
    localparam logic [31:0] FIFO = 32'h0000_1000;
    localparam logic [31:0] RAM  = 32'h0000_2000;
    localparam logic [31:0] TXQ  = 32'h0000_3000;
    logic core_clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [5:0] reg_addr_i = 6'h00;
    logic [31:0] reg_wdata_i = 32'h0000_0000;
    logic reg_write_i = 1'b0;
    logic reg_read_i = 1'b0;
    logic [31:0] reg_rdata_o, bus_addr_o, bus_wdata_o, bus_rdata_i;
    logic [15:0] hw_request_i = 16'h0000;
    logic bus_req_o, bus_write_o, guard_allow_i, busy_o, addr_error_o, req_overflow_o;
    logic [1:0] bus_size_o;
    logic [4:0] bus_ident_o;
    logic deny = 1'b0;
    int n_errors = 0;
    int num_checks = 0;
    int entry = 0;
    bit quiet = 0;
    bit track = 1;
    logic [31:0] rq [$];
    logic [63:0] wq [$];
    logic [31:0] rd;
    logic [63:0] e;
    int seed;
    always #10 core_clk_i = ~core_clk_i;
    cfd_channel dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_write_i(reg_write_i), .reg_read_i(reg_read_i), .reg_rdata_o(reg_rdata_o), .hw_request_i(hw_request_i),
        .bus_req_o(bus_req_o), .bus_write_o(bus_write_o), .bus_addr_o(bus_addr_o), .bus_wdata_o(bus_wdata_o),
        .bus_size_o(bus_size_o), .bus_ident_o(bus_ident_o), .bus_rdata_i(bus_rdata_i),
        .guard_allow_i(guard_allow_i), .busy_o(busy_o), .addr_error_o(addr_error_o), .req_overflow_o(req_overflow_o));
    cfd_mem_model #(.FIFO_BASE(FIFO)) far (.core_clk_i(core_clk_i), .bus_req_i(bus_req_o), .bus_write_i(bus_write_o),
        .bus_addr_i(bus_addr_o), .bus_wdata_i(bus_wdata_o), .bus_rdata_o(bus_rdata_i),
        .guard_allow_o(guard_allow_i), .deny_i(deny));
    function automatic logic [31:0] fw(int en, int i);
        return {en[15:0], i[15:0]} ^ 32'hA5A5_0000;
    endfunction
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic conclude();
        if (n_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic reg_wr(logic [5:0] a, logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_write_i <= 1'b1;
        @(posedge core_clk_i);
        reg_write_i <= 1'b0;
    endtask
    task automatic reg_rd(logic [5:0] a, output logic [31:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_read_i <= 1'b1;
        @(posedge core_clk_i);
        reg_read_i <= 1'b0;
        @(negedge core_clk_i);
        d = reg_rdata_o;
    endtask
    task automatic desc(int w, logic [31:0] v);
        reg_wr(cfd_pkg::OFF_DESC_POINTER, 32'(w) << cfd_pkg::POS_LINK);
        reg_wr(cfd_pkg::OFF_DESC_WINDOW, v);
    endtask
    task automatic setup(int n);
        int code;
        code = n < 4 ? 45 + n : 49 + n;
        for (int d = 0; d < 5; d++) begin
            desc(4 * d, d == 0 ? FIFO : RAM);
            desc(4 * d + 1, d == 0 ? RAM : TXQ + 32'(d - 1) * 32'h100);
            desc(4 * d + 2, cfd_pkg::BLOCK_BYTES);
            desc(4 * d + 3, (32'(d == 4 ? 0 : 4 * (d + 1)) << cfd_pkg::POS_LINK) | 32'h1);
        end
        reg_wr(cfd_pkg::OFF_DESC_POINTER, 32'h0000_0001);
        reg_wr(cfd_pkg::OFF_TRANSFER_MODE, 32'h0000_007A);
        reg_wr(cfd_pkg::OFF_TRIGGER_SEL, 32'(code) | (32'd95 << cfd_pkg::POS_TRANSFER_COUNT));
        reg_wr(cfd_pkg::OFF_DESC_UPDATE, 32'h0000_0007);
        reg_wr(cfd_pkg::OFF_TRANSFER_SIZE, 32'h0000_0000);
        reg_wr(cfd_pkg::OFF_BUFFER_CTRL, 32'h0000_0080);
        reg_wr(cfd_pkg::OFF_CHANNEL_CTRL, 32'h0000_0021);
    endtask
    task automatic pulse(int b);
        @(posedge core_clk_i);
        hw_request_i[b] <= 1'b1;
        @(posedge core_clk_i);
        hw_request_i[b] <= 1'b0;
    endtask
    task automatic wait_flag(ref logic f, input logic v, input int lim, input string what);
        int c;
        c = 0;
        while (f !== v && c < lim) begin
            @(negedge core_clk_i);
            c++;
        end
        chk(what, 32'(v), 32'(f));
    endtask
    task automatic run_frame(int b, bit ovf);
        for (int i = 0; i < 19; i++) begin
            rq.push_back(FIFO + 32'(4 * i));
            wq.push_back({RAM + 32'(4 * i), fw(entry, i)});
        end
        for (int k = 0; k < 4; k++) begin
            for (int i = 0; i < 19; i++) begin
                rq.push_back(RAM + 32'(4 * i));
                wq.push_back({TXQ + 32'(k) * 32'h100 + 32'(4 * i), fw(entry, i)});
            end
        end
        entry++;
        quiet = 1;
        pulse((b + 1) % 8);
        repeat (20) @(posedge core_clk_i);
        quiet = 0;
        pulse(b);
        wait_flag(busy_o, 1'b1, 10, "busy start");
        if (ovf) begin
            pulse(b);
            wait_flag(req_overflow_o, 1'b1, 4, "request overflow");
        end
        wait_flag(busy_o, 1'b0, 3000, "busy end");
        chk("pending reads", 32'h0, 32'(rq.size()));
        chk("pending writes", 32'h0, 32'(wq.size()));
    endtask
    always @(posedge core_clk_i) begin
        if (!srst_i && bus_req_o && track) begin
            if (quiet) chk("request while unselected", 32'h0, 32'h1);
            chk("access size", 32'(cfd_pkg::SIZE_LONGWORD), 32'(bus_size_o));
            chk("master ident", 32'(cfd_pkg::MASTER_IDENT_RESET), 32'(bus_ident_o));
            if (bus_write_o) begin
                e = wq.size() > 0 ? wq.pop_front() : 64'hFFFF_FFFF_FFFF_FFFF;
                chk("write address", e[63:32], bus_addr_o);
                chk("write data", e[31:0], bus_wdata_o);
            end else begin
                chk("read address", rq.size() > 0 ? rq.pop_front() : 32'hFFFF_FFFF, bus_addr_o);
            end
        end
    end
    initial begin
        #(20 * 40000);
        n_errors++;
        conclude();
    end
    initial begin
        seed = $urandom(32'h5630);
        repeat (3) @(posedge core_clk_i);
        srst_i <= 1'b0;
        reg_rd(cfd_pkg::OFF_CHANNEL_CTRL, rd);
        chk("control reset", cfd_pkg::CTRL_RESET, rd);
        reg_rd(cfd_pkg::OFF_TRANSFER_MODE, rd);
        chk("mode reset", cfd_pkg::MODE_RESET, rd);
        reg_rd(6'h3C, rd);
        chk("unmapped read", 32'h0000_0000, rd);
        for (int j = 0; j < 2; j++) begin
            e[31:0] = $urandom();
            reg_wr(j == 0 ? cfd_pkg::OFF_SCATTER_INC : cfd_pkg::OFF_SCATTER_CTRL, e[31:0]);
            reg_rd(j == 0 ? cfd_pkg::OFF_SCATTER_INC : cfd_pkg::OFF_SCATTER_CTRL, rd);
            chk("scatter readback", e[31:0], rd);
            reg_wr(j == 0 ? cfd_pkg::OFF_SCATTER_INC : cfd_pkg::OFF_SCATTER_CTRL, 32'h0000_0000);
        end
        for (int n = 0; n < 8; n++) begin
            setup(n);
            run_frame(n, 0);
            run_frame(n, 0);
        end
        run_frame(7, 1);
        track = 0;
        repeat (3000) @(posedge core_clk_i);
        srst_i <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        srst_i <= 1'b0;
        setup(0);
        deny <= 1'b1;
        pulse(0);
        wait_flag(addr_error_o, 1'b1, 50, "address error");
        wait_flag(busy_o, 1'b0, 20, "stop on error");
        conclude();
    end
endmodule
